// file: rtl/cms_defines.vh
// Constants for the converter mode sequencer
`ifndef CMS_DEFINES_VH
`define CMS_DEFINES_VH

// ---------------------------------------------------------------------
// Register map (word aligned byte addresses)
// ---------------------------------------------------------------------
`define CMS_ADDR_CTRL        4'h0
`define CMS_ADDR_STATUS      4'h4
`define CMS_ADDR_CONFIG      4'h8

// ---------------------------------------------------------------------
// Control register fields (first_control_register)
// ---------------------------------------------------------------------
`define CMS_CTRL_SWITCH_ENABLE_BIT_BIT    0
`define CMS_CTRL_DISCH_BIT   1
`define CMS_CTRL_SSC_BIT     2
`define CMS_CTRL_DVS_BIT     3
`define CMS_CTRL_RESET       4'h1

// ---------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------
`define CMS_ST_MODE_LSB      0
`define CMS_ST_MODE_MSB      4
`define CMS_ST_SECONDARY_BIT 5
`define CMS_ST_EXTCLK_BIT    6
`define CMS_ST_ILIM_BIT      7

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define CMS_INIT_TIME_US     400
`define CMS_CLK_MHZ          10
`define CMS_INIT_CYCLES      13'hfa0
`define CMS_SYNC_LOSS_CYC    8'h40

`endif

// file: rtl/cms_mode_sequencer.v
// Operating-mode sequencer of a stackable step-down converter
//
// Summary of operation
// - Below reset threshold: no functions, registers invalid
// - Rising above reset threshold enters lockout mode
// - Lockout from reset: nothing; from standby: discharge
// - Registers stay valid during lockout mode
// - Lockout exits to reset, to initialization until done once, or to standby
// - Standby while any enable condition fails
// - Standby keeps interface, discharge, power good
// - On only when all four conditions hold
// - On mode enables switching and every function except discharge
// - Any failed condition returns on to standby
// - Supply under lockout threshold forces lockout mode
// - Lockout, overvoltage, thermal faults pull enable low
// - Current limit clamps only own amplifier
// - Lost external clock falls back to internal on primary only
// - Power good, serial interface only in primary
// - Voltage scaling commanded by primary only
// - Spread spectrum passed down chain from primary
// - External clock only at primary; secondaries chain
// - Secondaries keep output discharge enabled in standby and in lockout entered from standby or on
// - Initialize 400 us, sample strap pins then
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "cms_defines.vh"

module cms_mode_sequencer (
    input  wire        clock_i,        // 10 MHz system clock
    input  wire        rst_n_i,        // Asynchronous reset, active low
    input  wire        wb_cyc_i,       // Wishbone cycle
    input  wire        wb_stb_i,       // Wishbone strobe
    input  wire        wb_we_i,        // Wishbone write enable
    input  wire [3:0]  wb_adr_i,       // Wishbone byte address
    input  wire [3:0]  wb_sel_i,       // Wishbone byte selects
    input  wire [31:0] wb_dat_i,       // Wishbone write data
    output reg  [31:0] wb_dat_o,       // Wishbone read data
    output reg         wb_ack_o,       // Wishbone acknowledge
    input  wire        supply_above_por_i,  // Supply over reset threshold
    input  wire        supply_above_undervoltage_lockout_i, // Supply over lockout threshold
    input  wire        supply_above_overvoltage_lockout_i, // Supply over overvoltage limit
    input  wire        temp_over_shdn_i,    // Junction over shutdown limit
    input  wire        current_limit_i,     // Own current limit active
    input  wire        enable_pin_i,        // Shared enable line level
    output wire        enable_pin_o,        // Enable line drive value (low)
    output wire        enable_pin_oe_o,     // Enable line pull-down active
    input  wire        vset1_pin_i,         // Voltage select strap 1
    input  wire        vset2_pin_i,         // Voltage select strap 2
    input  wire        sync_out_strap_i,    // High: output pin floats, primary
    input  wire        mode_sync_clk_i,     // Mode/sync input clock
    input  wire        osc_clk_i,           // Internal oscillator level
    output reg  [1:0]  vset_o,              // Latched voltage select
    output reg         secondary_o,         // Device is a stack secondary
    output reg  [4:0]  mode_o,              // One-hot operating mode
    output reg         switching_en_o,      // Power stage may switch
    output reg         discharge_en_o,      // Output discharge active
    output reg         serial_if_en_o,      // Serial interface available
    output reg         power_good_cmp_en_o, // Window comparator enabled
    output reg         dvs_en_o,            // Voltage scaling accepted
    output reg         ssc_en_o,            // Spread spectrum active
    output reg         ea_clamp_o,          // Error amplifier clamp
    output reg         soft_start_o,        // Pulse: new soft start
    output reg         phase_clk_o,         // Power stage timing source
    output reg         sync_out_o           // Chained sync output
);

// ---------------------------------------------------------------------
// States
// ---------------------------------------------------------------------
localparam [4:0] ST_POR   = 5'h01;
localparam [4:0] ST_UNDERVOLTAGE_LOCKOUT  = 5'h02;
localparam [4:0] ST_INIT  = 5'h04;
localparam [4:0] ST_STBY  = 5'h08;
localparam [4:0] ST_ON    = 5'h10;
localparam [12:0] INIT_CNT = `CMS_INIT_CYCLES;

// ---------------------------------------------------------------------
// Reset release and input synchronisers
// ---------------------------------------------------------------------
reg  [1:0] rst_sync_q;
wire       rst_n = rst_sync_q[1];

always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
        rst_sync_q <= 2'h0;
    else
        rst_sync_q <= {rst_sync_q[0], 1'b1};
end

reg  [10:0] s1_q;
reg  [10:0] s2_q;
wire [10:0] raw = {osc_clk_i, mode_sync_clk_i, sync_out_strap_i, vset2_pin_i,
                   vset1_pin_i, enable_pin_i, current_limit_i, temp_over_shdn_i,
                   supply_above_overvoltage_lockout_i, supply_above_undervoltage_lockout_i, supply_above_por_i};

always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        s1_q <= 11'h0;
        s2_q <= 11'h0;
    end else begin
        s1_q <= raw;
        s2_q <= s1_q;
    end
end

wire por_ok   = s2_q[0];
wire undervoltage_lockout_ok  = s2_q[1];
wire overvoltage_lockout     = s2_q[2];
wire tshut    = s2_q[3];
wire ilim     = s2_q[4];
wire en_pin   = s2_q[5];
wire ext_clk  = s2_q[9];
wire osc      = s2_q[10];

// ---------------------------------------------------------------------
// Registers
// ---------------------------------------------------------------------
reg  [3:0] ctrl_q;
reg  [3:0] ctrl_d;
reg        regs_valid_q;
reg  [4:0] state_q;
reg  [4:0] state_d;
reg  [12:0] init_cnt_q;
reg        initialized_q;
reg        from_stby_q;
reg        ext_clk_q;
reg  [7:0] sync_cnt_q;
reg        ext_lock_q;

wire switch_enable_bit      = ctrl_q[`CMS_CTRL_SWITCH_ENABLE_BIT_BIT];
wire on_ok     = en_pin & switch_enable_bit & ~tshut & ~overvoltage_lockout;
wire stack_flt = ~undervoltage_lockout_ok | overvoltage_lockout | tshut;

// Secondaries drop the serial interface, so register writes only land on primary
wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire bus_wr  = bus_req & wb_we_i & wb_sel_i[0] & ~secondary_o;

always @* begin
    ctrl_d = ctrl_q;
    if (bus_wr && wb_adr_i == `CMS_ADDR_CTRL && regs_valid_q)
        ctrl_d = wb_dat_i[3:0];
end

// ---------------------------------------------------------------------
// Mode state machine
// ---------------------------------------------------------------------
always @* begin
    state_d = state_q;
    case (state_q)
        ST_POR: begin
            if (por_ok)
                state_d = ST_UNDERVOLTAGE_LOCKOUT;
        end
        ST_UNDERVOLTAGE_LOCKOUT: begin
            if (undervoltage_lockout_ok)
                state_d = initialized_q ? ST_STBY : ST_INIT;
        end
        ST_INIT: begin
            if (!undervoltage_lockout_ok)
                state_d = ST_UNDERVOLTAGE_LOCKOUT;
            else if (init_cnt_q == INIT_CNT)
                state_d = ST_STBY;
        end
        ST_STBY: begin
            if (!undervoltage_lockout_ok)
                state_d = ST_UNDERVOLTAGE_LOCKOUT;
            else if (on_ok)
                state_d = ST_ON;
        end
        ST_ON: begin
            if (!undervoltage_lockout_ok)
                state_d = ST_UNDERVOLTAGE_LOCKOUT;
            else if (!on_ok)
                state_d = ST_STBY;
        end
        default: state_d = ST_POR;
    endcase
    if (!por_ok)
        state_d = ST_POR;
end

always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        state_q       <= ST_POR;
        ctrl_q        <= `CMS_CTRL_RESET;
        regs_valid_q  <= 1'b0;
        init_cnt_q    <= 13'h0;
        initialized_q <= 1'b0;
        from_stby_q   <= 1'b0;
        vset_o        <= 2'h0;
        secondary_o   <= 1'b0;
    end else begin
        state_q <= state_d;
        if (state_q == ST_POR) begin
            ctrl_q        <= `CMS_CTRL_RESET;
            regs_valid_q  <= 1'b0;
            initialized_q <= 1'b0;
        end else begin
            ctrl_q       <= ctrl_d;
            regs_valid_q <= 1'b1;
        end
        if (state_q == ST_INIT) begin
            init_cnt_q <= init_cnt_q + 13'h1;
            vset_o      <= s2_q[7:6];
            secondary_o <= ~s2_q[8];
            if (state_d == ST_STBY)
                initialized_q <= 1'b1;
        end else begin
            init_cnt_q <= 13'h0;
        end
        if (state_d == ST_UNDERVOLTAGE_LOCKOUT && state_q != ST_UNDERVOLTAGE_LOCKOUT)
            from_stby_q <= (state_q == ST_STBY) || (state_q == ST_ON);
    end
end

// ---------------------------------------------------------------------
// External clock watchdog
// ---------------------------------------------------------------------
// A clock edge must show within the window or a primary's power stage runs on
// the internal oscillator; hardware cannot tell a slow clock from none.
always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        ext_clk_q  <= 1'b0;
        sync_cnt_q <= 8'h0;
        ext_lock_q <= 1'b0;
    end else begin
        ext_clk_q <= ext_clk;
        if (ext_clk != ext_clk_q) begin
            sync_cnt_q <= 8'h0;
            ext_lock_q <= 1'b1;
        end else if (sync_cnt_q == `CMS_SYNC_LOSS_CYC) begin
            ext_lock_q <= 1'b0;
        end else begin
            sync_cnt_q <= sync_cnt_q + 8'h1;
        end
    end
end

// ---------------------------------------------------------------------
// Function enables
// ---------------------------------------------------------------------
wire in_on   = (state_q == ST_ON);
wire in_stby = (state_q == ST_STBY);
wire in_undervoltage_lockout = (state_q == ST_UNDERVOLTAGE_LOCKOUT);
wire live    = in_on | in_stby;

always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        mode_o              <= ST_POR;
        switching_en_o      <= 1'b0;
        discharge_en_o      <= 1'b0;
        serial_if_en_o      <= 1'b0;
        power_good_cmp_en_o <= 1'b0;
        dvs_en_o            <= 1'b0;
        ssc_en_o            <= 1'b0;
        ea_clamp_o          <= 1'b0;
        soft_start_o        <= 1'b0;
        phase_clk_o         <= 1'b0;
        sync_out_o          <= 1'b0;
    end else begin
        mode_o         <= state_q;
        switching_en_o <= in_on;
        discharge_en_o <= ~in_on & ((live | (in_undervoltage_lockout & from_stby_q))
                          & (ctrl_q[`CMS_CTRL_DISCH_BIT] | secondary_o));
        serial_if_en_o      <= live & ~secondary_o;
        power_good_cmp_en_o <= live & ~secondary_o;
        dvs_en_o   <= in_on & ~secondary_o & ctrl_q[`CMS_CTRL_DVS_BIT];
        ssc_en_o   <= in_on & ~secondary_o & ctrl_q[`CMS_CTRL_SSC_BIT];
        ea_clamp_o <= in_on & ilim;
        soft_start_o <= in_stby & (state_d == ST_ON);
        // Secondaries always take timing from the chain input
        phase_clk_o <= (ext_lock_q | secondary_o) ? ext_clk : osc;
        sync_out_o  <= (ext_lock_q | secondary_o) ? ext_clk : osc;
    end
end

// Pull the shared line low during start-up and on stack-wide faults only
assign enable_pin_o    = 1'b0;
assign enable_pin_oe_o = ~rst_n | ~live | stack_flt;

// ---------------------------------------------------------------------
// Wishbone slave
// ---------------------------------------------------------------------
always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
    end else begin
        wb_ack_o <= bus_req;
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `CMS_ADDR_CTRL:   wb_dat_o <= {28'h0, ctrl_q & {4{regs_valid_q}}};
                `CMS_ADDR_STATUS: wb_dat_o <= {24'h0, ilim, ext_lock_q,
                                               secondary_o, state_q};
                `CMS_ADDR_CONFIG: wb_dat_o <= {30'h0, vset_o};
                default:          wb_dat_o <= 32'h0;
            endcase
        end
    end
end

endmodule // cms_mode_sequencer

// file: sim/cms_props.sv
// Port checker for the converter mode sequencer
`timescale 1ns/100ps
module cms_props (
    input wire logic       clock_i,             // Clock
    input wire logic       rst_n_i,             // Reset
    input wire logic       wb_cyc_i,            // Bus cycle
    input wire logic       wb_stb_i,            // Bus strobe
    input wire logic       wb_ack_o,            // Bus ack
    input wire logic       supply_above_por_i,  // Reset threshold
    input wire logic       current_limit_i,     // Current limit
    input wire logic       enable_pin_i,        // Enable line
    input wire logic       enable_pin_oe_o,     // Enable pull-down
    input wire logic [4:0] mode_o,              // Mode
    input wire logic       switching_en_o,      // Switching
    input wire logic       discharge_en_o,      // Discharge
    input wire logic       serial_if_en_o,      // Serial interface
    input wire logic       power_good_cmp_en_o, // Window comparator
    input wire logic       secondary_o,         // Secondary
    input wire logic       ea_clamp_o,          // Amplifier clamp
    input wire logic       soft_start_o         // Soft start
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_onehot; $onehot(mode_o); endproperty
    a_onehot: assert property (p_onehot) else $error("mode not one-hot");
    property p_por; !supply_above_por_i |-> ##[1:4] mode_o == 5'h01; endproperty
    a_por: assert property (p_por) else $error("no reset mode");
    property p_por_off;
        mode_o == 5'h01 |-> !switching_en_o && !serial_if_en_o && !discharge_en_o;
    endproperty
    a_por_off: assert property (p_por_off) else $error("function in reset mode");
    property p_no_sw; (mode_o != 5'h10) [*2] |-> !switching_en_o; endproperty
    a_no_sw: assert property (p_no_sw) else $error("switching outside on");
    property p_sw; $rose(mode_o[4]) |-> switching_en_o && $past(soft_start_o); endproperty
    a_sw: assert property (p_sw) else $error("on entry without start");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing");
    property p_lock; mode_o == 5'h02 |-> $past(enable_pin_oe_o); endproperty
    a_lock: assert property (p_lock) else $error("lockout leaves enable");
    property p_sec; secondary_o |-> !serial_if_en_o && !power_good_cmp_en_o; endproperty
    a_sec: assert property (p_sec) else $error("secondary offers primary");
    property p_sec_dis; secondary_o && mode_o[3] |-> discharge_en_o; endproperty
    a_sec_dis: assert property (p_sec_dis) else $error("secondary discharge off");
    property p_ilim;
        $rose(current_limit_i) && mode_o[4] |-> ##[1:4] ea_clamp_o && !enable_pin_oe_o;
    endproperty
    a_ilim: assert property (p_ilim) else $error("current limit response");
    property p_off; mode_o[4] && !enable_pin_i |-> ##[1:4] !mode_o[4]; endproperty
    a_off: assert property (p_off) else $error("on held with enable low");
endmodule // cms_props

bind cms_mode_sequencer cms_props i_props (.clock_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .supply_above_por_i, .current_limit_i, .enable_pin_i, .enable_pin_oe_o,
    .mode_o, .switching_en_o, .discharge_en_o, .serial_if_en_o, .power_good_cmp_en_o,
    .secondary_o, .ea_clamp_o, .soft_start_o);

// file: sim/cms_stack_peer.sv
// Model of the stack peers: shared enable line and external sync clock
`timescale 1ns/100ps
module cms_stack_peer (
    input  wire logic clock_i,    // System clock
    input  wire logic dut_oe_i,   // Device pulls the line low
    input  wire logic fault_i,    // A peer pulls the line low
    input  wire logic run_clk_i,  // External clock present
    output wire logic en_line_o,  // Pulled-up shared enable
    output logic      sync_clk_o  // External sync clock
);
    // Open drain with pull-up: high only when nobody pulls
    assign en_line_o = !(dut_oe_i || fault_i);
    // Fed to the device in either role; a failed clock stands still
    initial sync_clk_o = 1'b0;
    always @(posedge clock_i) begin
        if (run_clk_i)
            sync_clk_o <= !sync_clk_o;
    end
endmodule // cms_stack_peer

// file: sim/test_cms_mode_sequencer.sv
// Self-checking bench of the converter mode sequencer
`timescale 1ns/100ps
module test_cms_mode_sequencer;
    logic clock_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, expq[$];
    logic supply_above_por_i = 0, supply_above_undervoltage_lockout_i = 0, supply_above_overvoltage_lockout_i = 0;
    logic temp_over_shdn_i = 0, current_limit_i = 0, vset1_pin_i = 0, vset2_pin_i = 0;
    logic sync_out_strap_i = 1, osc_clk_i = 0, pf = 1, run = 1, r;
    wire [31:0] wb_dat_o;
    wire [4:0] mode_o;
    wire [1:0] vset_o;
    wire wb_ack_o, enable_pin_i, enable_pin_o, enable_pin_oe_o, mode_sync_clk_i, secondary_o;
    wire switching_en_o, discharge_en_o, serial_if_en_o, power_good_cmp_en_o, dvs_en_o;
    wire ssc_en_o, ea_clamp_o, soft_start_o, phase_clk_o, sync_out_o;
    integer n_fail = 0, n_compared = 0, i, k;
    cms_mode_sequencer i_dut (.*);
    cms_stack_peer i_peer (.clock_i, .dut_oe_i(enable_pin_oe_o), .fault_i(pf),
        .run_clk_i(run), .en_line_o(enable_pin_i), .sync_clk_o(mode_sync_clk_i));
    initial begin
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i) osc_clk_i <= ~osc_clk_i;
    task chk(input string nm, input logic [31:0] e, s);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Read data is compared by the monitor, in request order
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        integer t;
        t = 0;
        @(posedge clock_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
        if (!w) expq.push_back(d);
        do begin @(posedge clock_i); t++; end while (wb_ack_o !== 1'b1 && t < 100);
        if (wb_ack_o !== 1'b1) n_fail++;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    always @(posedge clock_i) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && expq.size() > 0)
            chk("rdata", expq.pop_front(), wb_dat_o);
    end
    task wmode(input logic [4:0] m);
        integer t;
        t = 0;
        while (mode_o !== m && t < 5000) begin @(negedge clock_i); t++; end
        chk("mode", m, mode_o);
    endtask
    task end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clock_i);
        n_fail++;
        end_of_test;
    end
    initial begin
        void'($urandom(32));
        r = $urandom;
        {vset1_pin_i, vset2_pin_i} <= {r, r};
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1;
        repeat (3) @(posedge clock_i);
        wmode(5'h01);
        chk("en_o", 0, enable_pin_o);
        bus(1'b0, 4'h0, 32'h0);
        supply_above_por_i <= 1;
        wmode(5'h02);
        chk("sw", 0, switching_en_o);
        @(posedge clock_i) supply_above_undervoltage_lockout_i <= 1;
        wmode(5'h04);
        wmode(5'h08);
        chk("vset", {2{r}}, vset_o);
        chk("sec", 0, secondary_o);
        chk("sif", 1, serial_if_en_o);
        bus(1'b0, 4'h0, 32'h1);
        @(posedge clock_i) pf <= 0;
        wmode(5'h10);
        k = $urandom % 4;
        for (i = 0; i < 4; i++) begin
            case ((i + k) % 4)
                0: bus(1'b1, 4'h0, 32'h0);
                1: @(posedge clock_i) supply_above_overvoltage_lockout_i <= 1;
                2: @(posedge clock_i) temp_over_shdn_i <= 1;
                3: @(posedge clock_i) pf <= 1;
            endcase
            wmode(5'h08);
            if ((i + k) % 4 inside {1, 2}) chk("pull", 1, enable_pin_oe_o);
            bus(1'b1, 4'h0, 32'h1);
            @(posedge clock_i) {supply_above_overvoltage_lockout_i, temp_over_shdn_i, pf} <= 3'b000;
            wmode(5'h10);
        end
        bus(1'b1, 4'h0, 32'hf);
        repeat (3) @(negedge clock_i);
        chk("dvs", 1, dvs_en_o);
        chk("ssc", 1, ssc_en_o);
        @(posedge clock_i) current_limit_i <= 1;
        repeat (6) @(negedge clock_i);
        chk("clamp", 1, ea_clamp_o);
        chk("pull", 0, enable_pin_oe_o);
        bus(1'b0, 4'h4, 32'hd0);
        @(posedge clock_i) {current_limit_i, run} <= 2'b00;
        repeat (100) @(negedge clock_i);
        chk("mode", 5'h10, mode_o);
        bus(1'b0, 4'h4, 32'h10);
        @(negedge clock_i) k = {phase_clk_o, sync_out_o};
        @(negedge clock_i) chk("clk", k ^ 3, {phase_clk_o, sync_out_o});
        @(posedge clock_i) {supply_above_undervoltage_lockout_i, pf, run} <= 3'b011;
        wmode(5'h02);
        chk("dis", 1, discharge_en_o);
        @(posedge clock_i) supply_above_undervoltage_lockout_i <= 1;
        repeat (20) @(negedge clock_i);
        chk("mode", 5'h08, mode_o);
        bus(1'b1, 4'hc, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        bus(1'b0, 4'h0, 32'hf);
        @(posedge clock_i) supply_above_por_i <= 0;
        wmode(5'h01);
        bus(1'b0, 4'h0, 32'h0);
        @(posedge clock_i) {sync_out_strap_i, supply_above_por_i} <= 2'b01;
        wmode(5'h08);
        chk("sec", 1, secondary_o);
        chk("sif", 0, serial_if_en_o);
        chk("pgc", 0, power_good_cmp_en_o);
        chk("dis", 1, discharge_en_o);
        bus(1'b1, 4'h0, 32'h0);
        @(posedge clock_i) pf <= 0;
        wmode(5'h10);
        chk("dvs", 0, dvs_en_o);
        chk("ssc", 0, ssc_en_o);
        end_of_test;
    end
endmodule // test_cms_mode_sequencer
